// ===== psl_params.svh
// offsets, field positions, reset values and timing of the strap block
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH
// register offsets on the management bus
`define PSL_OFS_BASIC 5'h00
`define PSL_OFS_ADV 5'h04
`define PSL_OFS_SS1 5'h09
`define PSL_OFS_SS2 5'h0a
`define PSL_OFS_SS3 5'h0b
`define PSL_OFS_IND 5'h18
`define PSL_OFS_PHY 5'h19
`define PSL_OFS_RST 5'h1f
// basic mode control fields
`define PSL_BC_SPEED 13
`define PSL_BC_ANEN 12
`define PSL_BC_ISOLATE 10
`define PSL_BC_DUPLEX 8
// soft strap fields
`define PSL_SS1_DONE 15
`define PSL_SS1_MDIX 14
// phy control fields
`define PSL_PC_MDIX_EN 15
`define PSL_PC_MDIX_FORCE 14
`define PSL_PC_LEDCFG1 6
`define PSL_PC_LEDCFG0 5
// reset control fields
`define PSL_RC_SWRESET 15
`define PSL_RC_RESTART 14
// indicator control fields and reset value (blink code 2'b10 = 5 Hz)
`define PSL_IND_RATE_HI 10
`define PSL_IND_RATE_LO 9
`define PSL_IND_POL_ACT 8
`define PSL_IND_POL_SPD 7
`define PSL_IND_POL_LNK 6
`define PSL_IND_RST 16'h0400
// advertisement selector field and default address
`define PSL_ADV_SELECTOR 16'h0001
`define PSL_ADDR_RST 5'h01
// blink rates in hertz
`define PSL_BLINK_HZ0 20
`define PSL_BLINK_HZ1 10
`define PSL_BLINK_HZ2 5
`define PSL_BLINK_HZ3 2
// management frame lengths in bits
`define PSL_PREAMBLE_BITS 32
`define PSL_HDR_BITS 13
`define PSL_DATA_BITS 16
`endif

// ===== psl_pkg.sv
// types shared by the strap and indicator block
package psl_pkg;
  // management frame receiver states
  typedef enum logic [3:0] {
    PSL_S_PRE = 4'b0001,
    PSL_S_HDR = 4'b0010,
    PSL_S_TA = 4'b0100,
    PSL_S_DATA = 4'b1000
  } psl_mdio_state_t;
endpackage

// ===== psl_strap_ctrl.sv
// strap latch, soft strapping, mode control and indicators of a 10/100 phy
`timescale 1ns/1ps
`default_nettype none
`include "psl_params.svh"
module psl_strap_ctrl #(
  parameter int CLK_HZ = 10000000 // clock rate, shrink to speed up blink
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // strap-only pins
  input wire logic softStrapSelIn,
  input wire logic mdixStrapIn,
  input wire logic indicatorModeSelPin,
  // management bus
  input wire logic mdcIn,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // indicator pins, straps during reset
  input wire logic linkIndicatorIn,
  output logic linkIndicatorOut,
  output logic linkIndicatorOe,
  input wire logic speedIndicatorIn,
  output logic speedIndicatorOut,
  output logic speedIndicatorOe,
  input wire logic activityIndicatorIn,
  output logic activityIndicatorOut,
  output logic activityIndicatorOe,
  // mac receive pins, address straps during reset
  input wire logic colIn,
  output logic colOut,
  output logic colOe,
  input wire logic [3:0] rxdIn,
  output logic [3:0] rxdOut,
  output logic [3:0] rxdOe,
  output logic miiOutOe,
  // mac transmit path toward the core
  input wire logic txEnIn,
  input wire logic [3:0] txdIn,
  output logic txEnToCore,
  output logic [3:0] txdToCore,
  // status from the line core
  input wire logic coreColIn,
  input wire logic [3:0] coreRxdIn,
  input wire logic linkUpIn,
  input wire logic activityIn,
  input wire logic negotiationDoneIn,
  input wire logic partnerNegotiatesIn,
  input wire logic [3:0] partnerAbilityIn,
  input wire logic parallelSpeed100In,
  // control toward the line core
  output logic speed100Out,
  output logic fullDuplexOut,
  output logic mdixEnableOut,
  output logic mdixForceOut,
  output logic isolateOut,
  output logic lineIdleOnlyOut,
  output logic powerDownOut,
  output logic internalResetOut,
  output logic negotiationRestartOut
);
  // reset release chain
  logic rstSync1Reg, rstN;
  // latched pin straps, no reset, sampled while reset held
  logic hwAnEnReg, hwAn1Reg, hwAn0Reg, hwSelReg, hwMdixReg, hwLedReg;
  logic [4:0] hwAddrReg;
  // effective straps, survive soft reset
  logic [2:0] effAnReg;
  logic [4:0] effAddrReg;
  logic effMdixReg, effLedReg;
  // sequencing flags
  logic strapDoneReg, powerDownReg, intResetReg, swResetReg, loadDefaults;
  logic strapRise, cfgDone;
  // delayed latch strobe, defaults read the settled straps
  logic strapLoadReg;
  // register file
  logic [15:0] basicReg, advReg, ss1Reg, ss2Reg, ss3Reg, indReg, phyReg;
  // management write strobe
  logic regWrite;
  logic [4:0] regAddr;
  logic [15:0] regWdata, readData;
  // management frame receiver
  psl_pkg::psl_mdio_state_t mState;
  logic mdcPrevReg, mdcRise, isRead;
  logic [5:0] bitCnt;
  logic [12:0] hdrReg, hdrNext;
  logic [15:0] shiftReg;
  // resolution and indicators
  logic speed100Reg, fullReg;
  logic [31:0] blinkCnt, blinkLimit;
  logic blinkPhase;
  logic [3:0] common;

  // ability decode {100F,100H,10F,10H} from the effective mode straps
  function automatic logic [3:0] advDecode(input logic [2:0] an);
    case (an)
      3'b100: advDecode = 4'b0011;
      3'b101: advDecode = 4'b1100;
      3'b110: advDecode = 4'b0101;
      3'b111: advDecode = 4'b1111;
      3'b000: advDecode = 4'b0001;
      3'b001: advDecode = 4'b0010;
      3'b010: advDecode = 4'b0100;
      default: advDecode = 4'b1000;
    endcase
  endfunction

  // two-flop reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1Reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1Reg <= 1'b1;
      rstN <= rstSync1Reg;
    end
  end

  // shared pins are captured only while reset is held
  always_ff @(posedge clk) begin
    if (!rstN) begin
      hwAnEnReg <= activityIndicatorIn;
      hwAn1Reg <= speedIndicatorIn;
      hwAn0Reg <= linkIndicatorIn;
      hwAddrReg <= {rxdIn, colIn};
      hwSelReg <= softStrapSelIn;
      hwMdixReg <= mdixStrapIn;
      hwLedReg <= indicatorModeSelPin;
    end
  end

  assign strapRise = rstN && !strapDoneReg;
  assign cfgDone = regWrite && regAddr == `PSL_OFS_SS1 &&
                   regWdata[`PSL_SS1_DONE] && powerDownReg;
  assign loadDefaults = strapLoadReg || intResetReg || swResetReg;

  // power-down hold and configuration release
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strapDoneReg <= 1'b0;
      powerDownReg <= 1'b0;
      intResetReg <= 1'b0;
      strapLoadReg <= 1'b0;
    end else begin
      strapDoneReg <= 1'b1;
      // defaults wait one edge, the effective straps load on strapRise
      strapLoadReg <= strapRise;
      intResetReg <= cfgDone;
      if (strapRise) begin
        powerDownReg <= !hwSelReg;
      end else if (cfgDone) begin
        powerDownReg <= 1'b0;
      end
    end
  end

  // effective straps: pins first, soft values once configured
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      effAnReg <= 3'h0;
      effAddrReg <= `PSL_ADDR_RST;
      effMdixReg <= 1'b1;
      effLedReg <= 1'b0;
    end else if (strapRise) begin
      effAnReg <= {hwAnEnReg, hwAn1Reg, hwAn0Reg};
      effAddrReg <= hwAddrReg;
      effMdixReg <= hwMdixReg;
      effLedReg <= hwLedReg;
    end else if (cfgDone) begin
      effAnReg <= ss1Reg[2:0];
      effAddrReg <= ss2Reg[4:0];
      effMdixReg <= ss1Reg[`PSL_SS1_MDIX];
      effLedReg <= ss3Reg[0];
    end
  end

  // soft strap registers mirror the pins until software edits them
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ss1Reg <= 16'h4000;
      ss2Reg <= 16'h0001;
      ss3Reg <= 16'h0000;
    end else if (strapRise) begin
      ss1Reg <= {1'b0, hwMdixReg, 11'h000, hwAnEnReg, hwAn1Reg, hwAn0Reg};
      ss2Reg <= {11'h000, hwAddrReg};
      ss3Reg <= {15'h0000, hwLedReg};
    end else if (regWrite) begin
      if (regAddr == `PSL_OFS_SS1) begin
        ss1Reg <= {1'b0, regWdata[14:0]}; // done bit reads back zero
      end
      if (regAddr == `PSL_OFS_SS2) begin
        ss2Reg <= regWdata;
      end
      if (regAddr == `PSL_OFS_SS3) begin
        ss3Reg <= regWdata;
      end
    end
  end

  // mode registers: defaults from effective straps, then software writes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      basicReg <= 16'h0000;
      advReg <= `PSL_ADV_SELECTOR;
      indReg <= `PSL_IND_RST;
      phyReg <= 16'h8000;
      swResetReg <= 1'b0;
      negotiationRestartOut <= 1'b0;
    end else begin
      swResetReg <= regWrite && regAddr == `PSL_OFS_RST &&
                    regWdata[`PSL_RC_SWRESET];
      negotiationRestartOut <= regWrite && regAddr == `PSL_OFS_RST &&
                               regWdata[`PSL_RC_RESTART];
      if (loadDefaults) begin
        basicReg <= 16'h0000;
        basicReg[`PSL_BC_ANEN] <= effAnReg[2];
        basicReg[`PSL_BC_SPEED] <= effAnReg[1];
        basicReg[`PSL_BC_DUPLEX] <= effAnReg[0];
        advReg <= {7'h00, advDecode(effAnReg), 5'h01};
        indReg <= `PSL_IND_RST;
        phyReg <= {effMdixReg, 8'h00, 1'b0, effLedReg, effAddrReg};
      end else if (regWrite) begin
        case (regAddr)
          `PSL_OFS_BASIC: basicReg <= regWdata;
          `PSL_OFS_ADV: advReg <= regWdata;
          `PSL_OFS_IND: indReg <= regWdata;
          `PSL_OFS_PHY: phyReg <= {regWdata[15:5], effAddrReg};
          default: ;
        endcase
      end
    end
  end

  // register read mux, unmapped offsets read zero
  always_comb begin
    case (regAddr)
      `PSL_OFS_BASIC: readData = basicReg;
      `PSL_OFS_ADV: readData = advReg;
      `PSL_OFS_SS1: readData = ss1Reg;
      `PSL_OFS_SS2: readData = ss2Reg;
      `PSL_OFS_SS3: readData = ss3Reg;
      `PSL_OFS_IND: readData = indReg;
      `PSL_OFS_PHY: readData = phyReg;
      default: readData = 16'h0000;
    endcase
  end

  assign mdcRise = mdcIn && !mdcPrevReg;
  assign hdrNext = {hdrReg[11:0], mdioIn};

  // management frame receiver, answers in every mode
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mState <= psl_pkg::PSL_S_PRE;
      mdcPrevReg <= 1'b0;
      bitCnt <= 6'h00;
      hdrReg <= 13'h0000;
      shiftReg <= 16'h0000;
      isRead <= 1'b0;
      regAddr <= 5'h00;
      regWdata <= 16'h0000;
      regWrite <= 1'b0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      mdcPrevReg <= mdcIn;
      regWrite <= 1'b0;
      if (mdcRise) begin
        case (mState)
          psl_pkg::PSL_S_PRE: begin
            if (mdioIn) begin
              bitCnt <= (bitCnt == 6'd`PSL_PREAMBLE_BITS) ? bitCnt :
                        bitCnt + 6'd1;
            end else begin
              if (bitCnt == 6'd`PSL_PREAMBLE_BITS) begin
                mState <= psl_pkg::PSL_S_HDR;
              end
              bitCnt <= 6'h00;
            end
          end
          psl_pkg::PSL_S_HDR: begin
            hdrReg <= hdrNext;
            bitCnt <= bitCnt + 6'd1;
            if (bitCnt == 6'd`PSL_HDR_BITS - 6'd1) begin
              bitCnt <= 6'h00;
              regAddr <= hdrNext[4:0];
              isRead <= hdrNext[11:10] == 2'b10;
              if (hdrNext[12] && hdrNext[9:5] == effAddrReg &&
                  hdrNext[11] != hdrNext[10]) begin
                mState <= psl_pkg::PSL_S_TA;
              end else begin
                mState <= psl_pkg::PSL_S_PRE;
              end
            end
          end
          psl_pkg::PSL_S_TA: begin
            bitCnt <= bitCnt + 6'd1;
            if (bitCnt == 6'h00) begin
              mdioOe <= isRead; // drive the zero turnaround bit
              mdioOut <= 1'b0;
            end else begin
              bitCnt <= 6'h00;
              mState <= psl_pkg::PSL_S_DATA;
              mdioOut <= isRead & readData[15];
              shiftReg <= {readData[14:0], 1'b0};
            end
          end
          psl_pkg::PSL_S_DATA: begin
            bitCnt <= bitCnt + 6'd1;
            mdioOut <= shiftReg[15];
            shiftReg <= isRead ? {shiftReg[14:0], 1'b0} :
                        {shiftReg[14:0], mdioIn};
            if (bitCnt == 6'd`PSL_DATA_BITS - 6'd1) begin
              bitCnt <= 6'h00;
              mState <= psl_pkg::PSL_S_PRE;
              mdioOe <= 1'b0;
              regWrite <= !isRead;
              regWdata <= {shiftReg[14:0], mdioIn};
            end
          end
          default: mState <= psl_pkg::PSL_S_PRE;
        endcase
      end
    end
  end

  assign common = advReg[8:5] & partnerAbilityIn;

  // speed and duplex resolution
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      speed100Reg <= 1'b0;
      fullReg <= 1'b0;
    end else if (!basicReg[`PSL_BC_ANEN]) begin
      speed100Reg <= basicReg[`PSL_BC_SPEED];
      fullReg <= basicReg[`PSL_BC_DUPLEX];
    end else if (negotiationDoneIn && !partnerNegotiatesIn) begin
      speed100Reg <= parallelSpeed100In;
      fullReg <= 1'b0;
    end else if (negotiationDoneIn) begin
      speed100Reg <= common[3] || common[2];
      fullReg <= common[3] || (!common[2] && common[1]);
    end
  end

  // blink half period from the rate code
  always_comb begin
    case (indReg[`PSL_IND_RATE_HI:`PSL_IND_RATE_LO])
      2'b00: blinkLimit = 32'(CLK_HZ / (2 * `PSL_BLINK_HZ0));
      2'b01: blinkLimit = 32'(CLK_HZ / (2 * `PSL_BLINK_HZ1));
      2'b10: blinkLimit = 32'(CLK_HZ / (2 * `PSL_BLINK_HZ2));
      default: blinkLimit = 32'(CLK_HZ / (2 * `PSL_BLINK_HZ3));
    endcase
  end

  // blink phase generator
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      blinkCnt <= 32'h0;
      blinkPhase <= 1'b0;
    end else if (blinkCnt + 32'h1 >= blinkLimit) begin
      blinkCnt <= 32'h0;
      blinkPhase <= !blinkPhase;
    end else begin
      blinkCnt <= blinkCnt + 32'h1;
    end
  end

  // indicator pins, driven only once the straps are latched
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      linkIndicatorOut <= 1'b0;
      speedIndicatorOut <= 1'b0;
      activityIndicatorOut <= 1'b0;
      linkIndicatorOe <= 1'b0;
      speedIndicatorOe <= 1'b0;
      activityIndicatorOe <= 1'b0;
    end else begin
      linkIndicatorOe <= strapDoneReg;
      speedIndicatorOe <= strapDoneReg;
      activityIndicatorOe <= strapDoneReg;
      speedIndicatorOut <= speed100Reg ^ indReg[`PSL_IND_POL_SPD];
      if (phyReg[`PSL_PC_LEDCFG0]) begin
        linkIndicatorOut <= linkUpIn ^ indReg[`PSL_IND_POL_LNK];
        activityIndicatorOut <= activityIn ^ indReg[`PSL_IND_POL_ACT];
      end else begin
        linkIndicatorOut <= (linkUpIn && !(activityIn && blinkPhase)) ^
                            indReg[`PSL_IND_POL_LNK];
        activityIndicatorOut <= (phyReg[`PSL_PC_LEDCFG1] ? fullReg :
                                 coreColIn) ^ indReg[`PSL_IND_POL_ACT];
      end
    end
  end

  // mac interface with isolate, plus core control outputs
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      colOut <= 1'b0;
      colOe <= 1'b0;
      rxdOut <= 4'h0;
      rxdOe <= 4'h0;
      miiOutOe <= 1'b0;
      txEnToCore <= 1'b0;
      txdToCore <= 4'h0;
      isolateOut <= 1'b0;
      lineIdleOnlyOut <= 1'b0;
      mdixEnableOut <= 1'b0;
      mdixForceOut <= 1'b0;
      speed100Out <= 1'b0;
      fullDuplexOut <= 1'b0;
      powerDownOut <= 1'b0;
      internalResetOut <= 1'b0;
    end else begin
      colOut <= coreColIn;
      rxdOut <= coreRxdIn;
      colOe <= strapDoneReg && !basicReg[`PSL_BC_ISOLATE];
      rxdOe <= {4{strapDoneReg && !basicReg[`PSL_BC_ISOLATE]}};
      miiOutOe <= strapDoneReg && !basicReg[`PSL_BC_ISOLATE];
      txEnToCore <= txEnIn && !basicReg[`PSL_BC_ISOLATE];
      txdToCore <= basicReg[`PSL_BC_ISOLATE] ? 4'h0 : txdIn;
      isolateOut <= basicReg[`PSL_BC_ISOLATE];
      lineIdleOnlyOut <= basicReg[`PSL_BC_ISOLATE];
      mdixEnableOut <= phyReg[`PSL_PC_MDIX_EN];
      mdixForceOut <= phyReg[`PSL_PC_MDIX_FORCE];
      speed100Out <= speed100Reg;
      fullDuplexOut <= fullReg;
      powerDownOut <= powerDownReg;
      internalResetOut <= intResetReg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  sequence s_release;
    cfgDone ##1 intResetReg;
  endsequence

  a_isolate_float: assert property (basicReg[`PSL_BC_ISOLATE] |=>
    !colOe && rxdOe == 4'h0 && !miiOutOe)
    else $error("mac outputs driven during isolate");
  a_isolate_tx: assert property (basicReg[`PSL_BC_ISOLATE] |=>
    !txEnToCore) else $error("transmit enable passed during isolate");
  a_speed_led: assert property (strapDoneReg && $past(strapDoneReg) |->
    speedIndicatorOut == ($past(speed100Reg) ^
    $past(indReg[`PSL_IND_POL_SPD]))) else $error("speed indicator wrong");
  a_parallel_half: assert property (basicReg[`PSL_BC_ANEN] &&
    negotiationDoneIn && !partnerNegotiatesIn |=> !fullReg)
    else $error("parallel detect gave full duplex");
  a_config_release: assert property (s_release |-> !powerDownReg ##1
    internalResetOut && !powerDownOut) else $error("release sequence wrong");
  a_soft_hold: assert property (strapRise |=> powerDownReg == !hwSelReg)
    else $error("power-down hold does not follow select pin");
  a_adv_load: assert property (loadDefaults |=> advReg[8:5] ==
    advDecode($past(effAnReg))) else $error("advertisement not loaded");
  a_forced_mode: assert property (loadDefaults && !effAnReg[2] |=>
    basicReg[`PSL_BC_SPEED] == $past(effAnReg[1]) &&
    !basicReg[`PSL_BC_ANEN]) else $error("forced mode not loaded");
  a_resolve_top: assert property (basicReg[`PSL_BC_ANEN] &&
    negotiationDoneIn && partnerNegotiatesIn && common[3] |=>
    speed100Reg && fullReg) else $error("resolution missed 100 full");
  a_keep_straps: assert property (swResetReg |=>
    effAnReg == $past(effAnReg) && effAddrReg == $past(effAddrReg))
    else $error("soft reset changed latched straps");
endmodule
`default_nettype wire

// ===== psl_mgmt_station.sv
// management station model that runs frames on the serial bus
`timescale 1ns/1ps
`default_nettype none
module psl_mgmt_station (
  // clock
  input wire logic clk,
  // serial bus
  output logic mdc,
  output logic mdioDrv,
  input wire logic mdioWire
);
  // idle bus: clock low, data released to the pull-up
  initial begin
    mdc = 1'b0;
    mdioDrv = 1'b1;
  end
  // one bit: data moves with mdc low, line sampled just before the rise
  task automatic sendBit(input logic b, output logic s);
    repeat (2) @(posedge clk);
    #5 mdc = 1'b0;
    mdioDrv = b;
    repeat (2) @(posedge clk);
    #5 s = mdioWire;
    mdc = 1'b1;
  endtask
  // whole frame; a read releases the line for turnaround and data
  task automatic frame(input logic rd, input logic [4:0] pa, ra,
      input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, rd, ~rd, pa, ra};
    for (int i = 0; i < 32; i++) sendBit(1'b1, s);
    for (int i = 13; i >= 0; i--) sendBit(hdr[i], s);
    // turnaround: a read releases to the pull-up, a write sends 1 then 0
    sendBit(1'b1, s);
    sendBit(rd, s);
    for (int i = 15; i >= 0; i--) begin
      sendBit(rd | wd[i], s);
      q[i] = s;
    end
    sendBit(1'b1, s);
    repeat (4) @(posedge clk);
    #5 mdc = 1'b0; // bus clock rests low between frames
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the strap, mode and indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // design inputs
  logic clk, arst_n, softStrapSelIn, mdixStrapIn, indicatorModeSelPin;
  logic mdcIn, mdioIn, mdioDrv, linkIndicatorIn, speedIndicatorIn;
  logic activityIndicatorIn, colIn, txEnIn, coreColIn, linkUpIn;
  logic activityIn, negotiationDoneIn, partnerNegotiatesIn;
  logic parallelSpeed100In;
  logic [3:0] rxdIn, txdIn, coreRxdIn, partnerAbilityIn;
  // design outputs
  logic mdioOut, mdioOe, linkIndicatorOut, linkIndicatorOe;
  logic speedIndicatorOut, speedIndicatorOe, activityIndicatorOut;
  logic activityIndicatorOe, colOut, colOe, miiOutOe, txEnToCore;
  logic [3:0] rxdOut, rxdOe, txdToCore;
  logic speed100Out, fullDuplexOut, mdixEnableOut, mdixForceOut;
  logic isolateOut, lineIdleOnlyOut, powerDownOut, internalResetOut;
  logic negotiationRestartOut;
  // bench state
  int n_fail, checks, nPulse, nRestart, n;
  logic [15:0] q;
  logic [4:0] pa;
  logic [8:0] r;
  logic lv;
  // rows: straps {act,spd,link}, adv bits 8:5, speed, duplex
  localparam logic [8:0] ROWS [8] = '{9'h004, 9'h049, 9'h092, 9'h0e3,
    9'h10d, 9'h173, 9'h196, 9'h1ff};
  // shared line: device drives when enabled, else station or pull-up
  assign mdioIn = mdioOe ? mdioOut : mdioDrv;
  psl_strap_ctrl #(.CLK_HZ(400)) psl_strap_ctrl_inst (.*);
  psl_mgmt_station psl_mgmt_station_inst (.clk(clk), .mdc(mdcIn),
    .mdioDrv(mdioDrv), .mdioWire(mdioIn));
  // clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counts internal reset pulses
  initial nPulse = 0;
  always @(posedge clk) if (internalResetOut === 1'b1) nPulse++;
  // counts negotiation restart pulses
  initial nRestart = 0;
  always @(posedge clk) if (negotiationRestartOut === 1'b1) nRestart++;
  // advance k edges, then land just after the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic chk(input logic [15:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [4:0] ra);
    psl_mgmt_station_inst.frame(1'b1, pa, ra, 16'h0000, q);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    psl_mgmt_station_inst.frame(1'b0, pa, ra, wd, q);
  endtask
  // reset with strap levels on the shared pins
  task automatic doRst(input logic [2:0] an, input logic sel);
    arst_n = 1'b0;
    {activityIndicatorIn, speedIndicatorIn, linkIndicatorIn} = an;
    softStrapSelIn = sel;
    step(12);
    chk({mdioOe, linkIndicatorOe, miiOutOe, rxdOe}, 16'h0000, "hiz");
    arst_n = 1'b1;
    step(6);
  endtask
  // one half period of the link blink, bounded
  task automatic halfBlink();
    lv = linkIndicatorOut;
    n = 0;
    while (linkIndicatorOut === lv && n < 200) begin
      step(1);
      n++;
    end
    if (n >= 200) begin
      n_fail++;
      end_of_test();
    end
  endtask
  initial begin
    n_fail = 0;
    checks = 0;
    pa = 5'h01;
    arst_n = 1'b0;
    {softStrapSelIn, mdixStrapIn, indicatorModeSelPin} = 3'b110;
    {linkIndicatorIn, speedIndicatorIn, activityIndicatorIn} = 3'b000;
    {colIn, rxdIn, txEnIn, txdIn} = 10'h215;
    {coreColIn, coreRxdIn, linkUpIn, activityIn} = 7'h0c;
    {negotiationDoneIn, partnerNegotiatesIn} = 2'b11;
    partnerAbilityIn = 4'hf;
    parallelSpeed100In = 1'b0;
    step(1);
    // strap table, partner offering all four abilities
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      doRst(r[8:6], 1'b1);
      rd(5'h04);
      chk(q[8:0], {r[5:2], 5'h01}, "adv");
      chk({speed100Out, fullDuplexOut}, r[1:0], "mode");
      chk(speedIndicatorOut, r[1], "spdled");
      chk({powerDownOut, mdixEnableOut}, 2'b01, "wake");
      chk({linkIndicatorOe, speedIndicatorOe, activityIndicatorOe}, 3'h7,
        "oe");
    end
    // partner silent: parallel detect stays half duplex
    partnerNegotiatesIn = 1'b0;
    parallelSpeed100In = 1'b1;
    step(4);
    chk({speed100Out, fullDuplexOut}, 2'b10, "pdet");
    partnerNegotiatesIn = 1'b1;
    // isolate: mac pins float, transmit ignored, management answers
    wr(5'h00, 16'h3400);
    chk({isolateOut, lineIdleOnlyOut, miiOutOe, colOe}, 4'hc, "iso");
    chk({rxdOe, txEnToCore, txdToCore}, 16'h0000, "isotx");
    rd(5'h19);
    chk(q[4:0], 5'h01, "isord");
    wr(5'h00, 16'h3000);
    chk({miiOutOe, txEnToCore, txdToCore}, 6'h35, "noiso");
    chk({colOut, rxdOut, colOe, rxdOe}, 10'h07f, "macrx");
    // manual crossover with automatic crossover off
    wr(5'h19, 16'h4000);
    chk({mdixForceOut, mdixEnableOut}, 2'b10, "mdix");
    rd(5'h19);
    chk(q, 16'h4001, "phyctl");
    // mode 2 collision, mode 3 duplex, blink, polarity
    coreColIn = 1'b1;
    step(4);
    chk(activityIndicatorOut, 1'b1, "col");
    coreColIn = 1'b0;
    wr(5'h19, 16'h0040);
    chk(activityIndicatorOut, 1'b1, "fdx");
    rd(5'h18);
    chk(q, 16'h0400, "indrst");
    {linkUpIn, activityIn} = 2'b11;
    halfBlink();
    halfBlink();
    chk(n > 37 && n < 43, 1'b1, "blink");
    wr(5'h18, 16'h0480);
    chk(speedIndicatorOut, 1'b0, "pol");
    // mode 1: steady link, activity follows the activity input
    wr(5'h19, 16'h0020);
    chk({linkIndicatorOut, activityIndicatorOut}, 2'b11, "mode1");
    activityIn = 1'b0;
    step(4);
    chk({linkIndicatorOut, activityIndicatorOut}, 2'b10, "mode1idle");
    // address straps {rxd,col}; old address no longer answers
    {rxdIn, colIn} = 5'h14;
    doRst(3'b111, 1'b1);
    rd(5'h19);
    chk(q, 16'hffff, "oldaddr");
    pa = 5'h14;
    rd(5'h0a);
    chk(q[4:0], 5'h14, "addr");
    // soft strapping: wake powered down, program, release
    {colIn, rxdIn} = 5'h10;
    pa = 5'h01;
    doRst(3'b000, 1'b0);
    chk(powerDownOut, 1'b1, "pdown");
    wr(5'h09, 16'h0005);
    wr(5'h09, 16'h8005);
    chk({powerDownOut, nPulse > 0}, 2'b01, "release");
    rd(5'h04);
    chk(q[8:5], 4'hc, "swadv");
    chk(mdixEnableOut, 1'b0, "swmdix");
    wr(5'h1f, 16'hc000);
    step(4);
    rd(5'h04);
    chk(q[8:5], 4'hc, "keep");
    chk(nRestart == 1, 1'b1, "restart");
    end_of_test();
  end
endmodule
`default_nettype wire
